// ### hw/qt_scale_pkg.sv
// Constants, layouts and types shared by the quick-trip scale-select block
package qt_scale_pkg;

  // Table and slave addresses
  localparam logic [7:0] TABLE_CFG = 8'h02;
  localparam logic [7:0] SLAVE_TX1 = 8'ha2;
  localparam logic [7:0] SLAVE_TX2 = 8'hb2;

  // Register offsets within the configuration table
  localparam logic [7:0] OFF_TX2_SCALE = 8'h8c;
  localparam logic [7:0] OFF_TX1_SCALE = 8'h8d;

  // Reset, factory and field layout
  localparam logic [7:0] SCALE_RESET = 8'h00;
  localparam logic [7:0] SCALE_LIVE_MASK = 8'h77;
  localparam int BIAS_LSB = 4;
  localparam int POWER_LSB = 0;
  localparam int CODE_W = 3;
  localparam logic [2:0] CODE_DEFAULT = 3'h0;

  // Value returned for a read without permission
  localparam logic [7:0] DENIED_RDATA = 8'hff;

  // Timing of one nonvolatile programming cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int NV_WRITE_NS = 1000;
  localparam int NV_WRITE_CYC_INT = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] NV_WRITE_CYC = 8'(NV_WRITE_CYC_INT);

  // Control states, Gray along load, idle, program
  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_IDLE = 2'h1,
    ST_PROG = 2'h3
  } ctl_fsm_t;

  // Memory access request from the serial engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] slave;
    logic [7:0] table_sel;
    logic [7:0] offset;
    logic [7:0] wdata;
  } mem_req_t;

  // Password and table permission levels
  typedef struct packed {
    logic higher_password_level;
    logic lower_password_level;
    logic table2_write_permit;
    logic table2_read_permit;
  } access_t;

  // Decoded full-scale selection for one monitor input
  typedef struct packed {
    logic [2:0] code;
    logic [15:0] pct_x100;
    logic [15:0] fs_mv;
  } scale_out_t;

  // Working copy and nonvolatile cell of one byte
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] nv;
  } byte_state_t;

  // Control state of the top module
  typedef struct packed {
    ctl_fsm_t fsm;
    logic [7:0] cnt;
    logic rd_ack;
    logic wr_ack;
    logic [7:0] rdata;
  } ctl_state_t;

endpackage : qt_scale_pkg

// ### hw/quick_trip_fullscale_select.sv
// Quick-trip full-scale select bytes for both transmitters
`timescale 1ns/10ps
module quick_trip_fullscale_select #(
  parameter int PROG_CYCLES = qt_scale_pkg::NV_WRITE_CYC_INT
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Factory initialisation of the nonvolatile cells
  input wire logic FACTORY_LOAD,
  // Memory access from the serial engine
  input wire qt_scale_pkg::mem_req_t MEM_REQ,
  input wire qt_scale_pkg::access_t ACCESS,
  // Memory answer
  output logic MEM_HIT,
  output logic MEM_RD_ACK,
  output logic [7:0] MEM_RDATA,
  output logic MEM_WR_ACK,
  output logic NV_BUSY,
  // Scale selections to the quick-trip comparators
  output qt_scale_pkg::scale_out_t TX2_BIAS,
  output qt_scale_pkg::scale_out_t TX2_POWER,
  output qt_scale_pkg::scale_out_t TX1_BIAS,
  output qt_scale_pkg::scale_out_t TX1_POWER
);

  // Programming count must fit the counter
  if (PROG_CYCLES < 1 || PROG_CYCLES > 255) begin : g_bad_prog
    $error("PROG_CYCLES out of range");
  end

  // Bound for the programming wait check
  localparam int PROG_MAX = 260;

  // Control state and its next value
  qt_scale_pkg::ctl_state_t st_ff;
  qt_scale_pkg::ctl_state_t nxt_st;

  // Decode and permission terms
  logic slave_ok;
  logic table_ok;
  logic sel_tx2;
  logic sel_tx1;
  logic hit;
  logic read_ok;
  logic write_ok;
  logic wr_take;
  // Working bytes
  logic [7:0] tx2_byte;
  logic [7:0] tx1_byte;

  // Address decode, shared over both slave addresses
  always_comb begin
    slave_ok = (MEM_REQ.slave == qt_scale_pkg::SLAVE_TX1) ||
               (MEM_REQ.slave == qt_scale_pkg::SLAVE_TX2);
    table_ok = MEM_REQ.table_sel == qt_scale_pkg::TABLE_CFG;
    sel_tx2 = MEM_REQ.offset == qt_scale_pkg::OFF_TX2_SCALE;
    sel_tx1 = MEM_REQ.offset == qt_scale_pkg::OFF_TX1_SCALE;
    hit = slave_ok && table_ok && (sel_tx2 || sel_tx1);
  end

  // Password gating
  always_comb begin
    read_ok = ACCESS.higher_password_level ||
              (ACCESS.lower_password_level &&
               (ACCESS.table2_write_permit || ACCESS.table2_read_permit));
    write_ok = ACCESS.higher_password_level ||
               (ACCESS.lower_password_level && ACCESS.table2_write_permit);
    wr_take = MEM_REQ.wr && hit && write_ok && (st_ff.fsm == qt_scale_pkg::ST_IDLE);
  end

  // Next control state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_ack = 1'b0;
    nxt_st.wr_ack = 1'b0;
    case (st_ff.fsm)
      qt_scale_pkg::ST_LOAD: begin
        nxt_st.fsm = qt_scale_pkg::ST_IDLE;
      end
      // Accept a write and start programming
      qt_scale_pkg::ST_IDLE: begin
        if (wr_take) begin
          nxt_st.fsm = qt_scale_pkg::ST_PROG;
          nxt_st.cnt = 8'(PROG_CYCLES - 1);
          nxt_st.wr_ack = 1'b1;
        end
      end
      // Count down the programming time
      qt_scale_pkg::ST_PROG: begin
        if (st_ff.cnt == 8'h00) begin
          nxt_st.fsm = qt_scale_pkg::ST_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      default: begin
        nxt_st.fsm = qt_scale_pkg::ST_LOAD;
      end
    endcase
    // Read answer one cycle after the request
    if (MEM_REQ.rd && hit) begin
      nxt_st.rd_ack = 1'b1;
      if (!read_ok) begin
        nxt_st.rdata = qt_scale_pkg::DENIED_RDATA;
      end else if (sel_tx2) begin
        nxt_st.rdata = tx2_byte;
      end else begin
        nxt_st.rdata = tx1_byte;
      end
    end
  end

  // Control register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_ff.fsm <= qt_scale_pkg::ST_LOAD;
      st_ff.cnt <= 8'h00;
      st_ff.rd_ack <= 1'b0;
      st_ff.wr_ack <= 1'b0;
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  scale_byte_reg u_tx2_byte (
    .clk(SYS_CLK),
    .rst(RST),
    .factory_load(FACTORY_LOAD),
    .load(st_ff.fsm == qt_scale_pkg::ST_LOAD),
    .wr_en(wr_take && sel_tx2),
    .wdata(MEM_REQ.wdata),
    .work(tx2_byte)
  );

  scale_byte_reg u_tx1_byte (
    .clk(SYS_CLK),
    .rst(RST),
    .factory_load(FACTORY_LOAD),
    .load(st_ff.fsm == qt_scale_pkg::ST_LOAD),
    .wr_en(wr_take && sel_tx1),
    .wdata(MEM_REQ.wdata),
    .work(tx1_byte)
  );

  scale_decode #(.IS_POWER(1'b0)) u_tx2_bias (
    .clk(SYS_CLK),
    .rst(RST),
    .code(tx2_byte[qt_scale_pkg::BIAS_LSB +: qt_scale_pkg::CODE_W]),
    .scale(TX2_BIAS)
  );

  scale_decode #(.IS_POWER(1'b1)) u_tx2_power (
    .clk(SYS_CLK),
    .rst(RST),
    .code(tx2_byte[qt_scale_pkg::POWER_LSB +: qt_scale_pkg::CODE_W]),
    .scale(TX2_POWER)
  );

  scale_decode #(.IS_POWER(1'b0)) u_tx1_bias (
    .clk(SYS_CLK),
    .rst(RST),
    .code(tx1_byte[qt_scale_pkg::BIAS_LSB +: qt_scale_pkg::CODE_W]),
    .scale(TX1_BIAS)
  );

  scale_decode #(.IS_POWER(1'b1)) u_tx1_power (
    .clk(SYS_CLK),
    .rst(RST),
    .code(tx1_byte[qt_scale_pkg::POWER_LSB +: qt_scale_pkg::CODE_W]),
    .scale(TX1_POWER)
  );

  // Answer outputs
  assign MEM_HIT = hit;
  assign MEM_RD_ACK = st_ff.rd_ack;
  assign MEM_RDATA = st_ff.rdata;
  assign MEM_WR_ACK = st_ff.wr_ack;
  assign NV_BUSY = st_ff.fsm == qt_scale_pkg::ST_PROG;

  // Checks, all in the system clock domain
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Granted write request and its effect
  sequence s_tx2_write;
    wr_take && sel_tx2;
  endsequence

  sequence s_tx2_applied;
    ##1 tx2_byte == (($past(MEM_REQ.wdata)) & qt_scale_pkg::SCALE_LIVE_MASK)
    ##1 TX2_BIAS.code == tx2_byte[6:4];
  endsequence

  a_tx2_write_apply: assert property (s_tx2_write |-> s_tx2_applied)
    else $error("Tx2 write not applied to scale code");

  // Same chain for the transmitter-1 byte, power field
  sequence s_tx1_write;
    wr_take && sel_tx1;
  endsequence

  sequence s_tx1_applied;
    ##1 tx1_byte == (($past(MEM_REQ.wdata)) & qt_scale_pkg::SCALE_LIVE_MASK)
    ##1 TX1_POWER.code == tx1_byte[2:0];
  endsequence

  a_tx1_write_apply: assert property (s_tx1_write |-> s_tx1_applied)
    else $error("Tx1 write not applied to scale code");

  a_write_denied_hold: assert property (
    (MEM_REQ.wr && hit && !write_ok) |=> ($stable(tx2_byte) && $stable(tx1_byte) && !MEM_WR_ACK))
    else $error("Write without permission changed a byte");

  a_read_denied_data: assert property (
    (MEM_REQ.rd && hit && !read_ok) |=> (MEM_RD_ACK && MEM_RDATA == 8'hff))
    else $error("Read without permission returned data");

  a_read_tx1_data: assert property (
    (MEM_REQ.rd && hit && read_ok && sel_tx1 && MEM_REQ.slave == 8'hb2)
    |=> (MEM_RDATA == $past(tx1_byte)))
    else $error("Tx1 byte differs under second slave address");

  a_reserved_bits_zero: assert property (
    tx2_byte[7] == 1'b0 && tx2_byte[3] == 1'b0 && tx1_byte[7] == 1'b0 && tx1_byte[3] == 1'b0)
    else $error("Reserved scale bit set");

  a_prog_busy_span: assert property (
    $rose(NV_BUSY) |-> NV_BUSY [*1] ##[0:PROG_MAX] !NV_BUSY)
    else $error("Programming cycle did not end");

  a_prog_no_accept: assert property (
    NV_BUSY |=> !MEM_WR_ACK)
    else $error("Write accepted while programming");

  a_bias_full_scale: assert property (
    (TX2_BIAS.code == 3'h0) |-> (TX2_BIAS.fs_mv == 16'h04e2 && TX2_BIAS.pct_x100 == 16'h2710))
    else $error("Tx2 bias code zero not full scale");

  a_power_low_end: assert property (
    (TX1_POWER.code == 3'h7) |-> (TX1_POWER.fs_mv == 16'h0275 && TX1_POWER.pct_x100 == 16'h09cc))
    else $error("Tx1 power code seven wrong");

  a_tx1_bias_track: assert property (
    $changed(tx1_byte[6:4]) |=> (TX1_BIAS.code == $past(tx1_byte[6:4])))
    else $error("Tx1 bias code not presented");

  a_tx2_bias_track: assert property (
    $changed(tx2_byte[6:4]) |=> (TX2_BIAS.code == $past(tx2_byte[6:4])))
    else $error("Tx2 bias code not presented");

  a_tx2_power_track: assert property (
    $changed(tx2_byte[2:0]) |=> (TX2_POWER.code == $past(tx2_byte[2:0])))
    else $error("Tx2 power code not presented");

  a_tx1_power_track: assert property (
    $changed(tx1_byte[2:0]) |=> (TX1_POWER.code == $past(tx1_byte[2:0])))
    else $error("Tx1 power code not presented");

  a_read_tx2_data: assert property (
    (MEM_REQ.rd && hit && read_ok && sel_tx2)
    |=> (MEM_RD_ACK && MEM_RDATA == $past(tx2_byte)))
    else $error("Tx2 byte read back wrong");

  a_read_ack_given: assert property (
    (MEM_REQ.rd && hit) |=> MEM_RD_ACK)
    else $error("Read of a scale byte not answered");

  a_wr_ack_busy: assert property (
    MEM_WR_ACK |-> NV_BUSY)
    else $error("Write acknowledged without programming");

endmodule : quick_trip_fullscale_select

// ### hw/scale_byte_reg.sv
// One shadowed nonvolatile scale-select byte
`timescale 1ns/10ps
module scale_byte_reg (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic factory_load,
  // Control
  input wire logic load,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // Working value
  output logic [7:0] work
);

  // Register and its next value
  qt_scale_pkg::byte_state_t st_ff;
  qt_scale_pkg::byte_state_t nxt_st;

  // Next state: restore, write or hold
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.work = st_ff.nv & qt_scale_pkg::SCALE_LIVE_MASK;
    end else if (wr_en) begin
      nxt_st.work = wdata & qt_scale_pkg::SCALE_LIVE_MASK;
      nxt_st.nv = wdata & qt_scale_pkg::SCALE_LIVE_MASK;
    end
    if (factory_load) begin
      nxt_st.nv = qt_scale_pkg::SCALE_RESET;
    end
  end

  // Working copy clears on reset; cell survives it
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff.work <= qt_scale_pkg::SCALE_RESET;
      st_ff.nv <= nxt_st.nv;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign work = st_ff.work;

endmodule : scale_byte_reg

// ### hw/scale_decode.sv
// Registered decode of a 3-bit full-scale code
`timescale 1ns/10ps
module scale_decode #(
  parameter bit IS_POWER = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Code in, decode out
  input wire logic [2:0] code,
  output qt_scale_pkg::scale_out_t scale
);

  // Registered decode and next value
  qt_scale_pkg::scale_out_t st_ff;
  qt_scale_pkg::scale_out_t nxt_st;

  // Percent and millivolt tables
  always_comb begin
    nxt_st.code = code;
    case (code)
      3'h0: begin
        nxt_st.pct_x100 = 16'h2710;
        nxt_st.fs_mv = IS_POWER ? 16'h09cb : 16'h04e2;
      end
      3'h1: begin
        nxt_st.pct_x100 = 16'h1f43;
        nxt_st.fs_mv = IS_POWER ? 16'h07d6 : 16'h03e8;
      end
      3'h2: begin
        nxt_st.pct_x100 = 16'h1a0f;
        nxt_st.fs_mv = IS_POWER ? 16'h0688 : 16'h0342;
      end
      3'h3: begin
        nxt_st.pct_x100 = 16'h138f;
        nxt_st.fs_mv = IS_POWER ? 16'h04e7 : 16'h0272;
      end
      3'h4: begin
        nxt_st.pct_x100 = 16'h0fa8;
        nxt_st.fs_mv = IS_POWER ? 16'h03ed : 16'h01f5;
      end
      3'h5: begin
        nxt_st.pct_x100 = 16'h0d0d;
        nxt_st.fs_mv = IS_POWER ? 16'h0346 : 16'h01a2;
      end
      3'h6: begin
        nxt_st.pct_x100 = 16'h0b31;
        nxt_st.fs_mv = IS_POWER ? 16'h02ce : 16'h0166;
      end
      // Smallest range
      default: begin
        nxt_st.pct_x100 = 16'h09cc;
        nxt_st.fs_mv = IS_POWER ? 16'h0275 : 16'h013a;
      end
    endcase
  end

  // Reset to the full-scale entry
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff.code <= qt_scale_pkg::CODE_DEFAULT;
      st_ff.pct_x100 <= 16'h2710;
      st_ff.fs_mv <= IS_POWER ? 16'h09cb : 16'h04e2;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign scale = st_ff;

endmodule : scale_decode

// ### tb/host_model.sv
// Host access model driving the memory request port of the block
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic clk,
  // Request and password levels to the block
  output qt_scale_pkg::mem_req_t req,
  output qt_scale_pkg::access_t acc,
  // Answer from the block
  input wire logic rd_ack,
  input wire logic [7:0] rdata,
  input wire logic wr_ack
);
  // Idle request and no password at time zero
  initial begin
    req = '0;
    acc = '0;
  end

  // Change password levels just after an edge
  task automatic set_acc(input logic [3:0] a);
    @(posedge clk);
    #1;
    acc = qt_scale_pkg::access_t'(a);
  endtask : set_acc

  // One access: launch after an edge, take the answer after the next one
  task automatic xfer(input logic w, input logic [7:0] sl, input logic [7:0] tb,
                      input logic [7:0] off, input logic [7:0] wd,
                      output logic ack, output logic [7:0] rd);
    @(posedge clk);
    #1;
    req.rd = ~w;
    req.wr = w;
    req.slave = sl;
    req.table_sel = tb;
    req.offset = off;
    req.wdata = wd;
    @(posedge clk);
    #1;
    ack = w ? wr_ack : rd_ack;
    rd = rdata;
    // Released data lines must not keep their last value
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.wdata = ~wd;
  endtask : xfer
endmodule : host_model

// ### tb/testbench.sv
// Self-checking bench for the quick-trip full-scale select bytes
`timescale 1ns/10ps
module testbench;
  // Short programming time keeps the run brief
  localparam int PROG = 4;
  // Clock, reset and factory load
  logic sys_clk;
  logic rst;
  logic factory_load;
  // Request and answer
  qt_scale_pkg::mem_req_t mem_req;
  qt_scale_pkg::access_t access;
  logic mem_hit;
  logic mem_rd_ack;
  logic mem_wr_ack;
  logic nv_busy;
  logic [7:0] mem_rdata;
  // Scale outputs
  qt_scale_pkg::scale_out_t tx2_bias;
  qt_scale_pkg::scale_out_t tx2_power;
  qt_scale_pkg::scale_out_t tx1_bias;
  qt_scale_pkg::scale_out_t tx1_power;
  // Result counters
  int error_cnt;
  int n_checks;
  // Expected percent and millivolt tables by code
  logic [15:0] pct_t [8] = '{16'h2710, 16'h1f43, 16'h1a0f, 16'h138f,
                             16'h0fa8, 16'h0d0d, 16'h0b31, 16'h09cc};
  logic [15:0] bmv_t [8] = '{16'h04e2, 16'h03e8, 16'h0342, 16'h0272,
                             16'h01f5, 16'h01a2, 16'h0166, 16'h013a};
  logic [15:0] pmv_t [8] = '{16'h09cb, 16'h07d6, 16'h0688, 16'h04e7,
                             16'h03ed, 16'h0346, 16'h02ce, 16'h0275};

  quick_trip_fullscale_select #(.PROG_CYCLES(PROG)) u_quick_trip_fullscale_select (
    .SYS_CLK(sys_clk), .RST(rst), .FACTORY_LOAD(factory_load),
    .MEM_REQ(mem_req), .ACCESS(access), .MEM_HIT(mem_hit),
    .MEM_RD_ACK(mem_rd_ack), .MEM_RDATA(mem_rdata), .MEM_WR_ACK(mem_wr_ack),
    .NV_BUSY(nv_busy), .TX2_BIAS(tx2_bias), .TX2_POWER(tx2_power),
    .TX1_BIAS(tx1_bias), .TX1_POWER(tx1_power)
  );

  host_model u_host_model (
    .clk(sys_clk), .req(mem_req), .acc(access),
    .rd_ack(mem_rd_ack), .rdata(mem_rdata), .wr_ack(mem_wr_ack)
  );

  // Free-running clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Bounded wait for programming to end
  task automatic idle();
    int i;
    for (i = 0; i < 20 && nv_busy !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 20) begin
      error_cnt++;
      summarize();
    end
  endtask : idle

  // Write to table two, check acceptance, let programming finish
  task automatic wr(input logic [7:0] sl, input logic [7:0] off, input logic [7:0] d,
                    input logic exp);
    logic ack;
    logic [7:0] rd;
    u_host_model.xfer(1'b1, sl, 8'h02, off, d, ack, rd);
    check(16'(ack), 16'(exp));
    check(16'(nv_busy), 16'(exp));
    idle();
  endtask : wr

  // Read from table two and compare
  task automatic rd(input logic [7:0] sl, input logic [7:0] off, input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    u_host_model.xfer(1'b0, sl, 8'h02, off, 8'h00, ack, d);
    check(16'(ack), 16'h0001);
    check(16'(d), 16'(exp));
    check(16'(mem_hit), 16'h0001);
  endtask : rd

  // Compare one decoded scale output against the tables
  task automatic scl(input qt_scale_pkg::scale_out_t s, input logic [2:0] c, input logic pw);
    check(16'(s.code), 16'(c));
    check(s.pct_x100, pct_t[c]);
    check(s.fs_mv, pw ? pmv_t[c] : bmv_t[c]);
  endtask : scl

  // Main sequence
  initial begin
    logic ack;
    logic [7:0] d;
    logic [7:0] cur;
    logic ew;
    int c;
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    factory_load = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    factory_load = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    u_host_model.set_acc(4'h8);
    rd(8'ha2, 8'h8c, 8'h00);
    rd(8'ha2, 8'h8d, 8'h00);
    scl(tx2_bias, 3'h0, 1'b0);
    scl(tx1_power, 3'h0, 1'b1);
    for (c = 0; c < 8; c++) begin
      wr(8'ha2, 8'h8c, {1'b1, 3'(c), 1'b1, 3'(7 - c)}, 1'b1);
      rd(8'hb2, 8'h8c, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
      scl(tx2_bias, 3'(c), 1'b0);
      scl(tx2_power, 3'(7 - c), 1'b1);
      wr(8'hb2, 8'h8d, {1'b1, 3'(7 - c), 1'b1, 3'(c)}, 1'b1);
      rd(8'ha2, 8'h8d, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      scl(tx1_bias, 3'(7 - c), 1'b0);
      scl(tx1_power, 3'(c), 1'b1);
    end
    cur = 8'h70;
    for (c = 0; c < 16; c++) begin
      u_host_model.set_acc(4'(c));
      ew = c[3] | (c[2] & c[1]);
      wr(8'ha2, 8'h8c, {1'b0, 3'(c), 1'b0, 3'(c + 1)}, ew);
      cur = ew ? {1'b0, 3'(c), 1'b0, 3'(c + 1)} : cur;
      rd(8'ha2, 8'h8c, (c[3] | (c[2] & (c[1] | c[0]))) ? cur : 8'hff);
    end
    // Write while programming is dropped
    u_host_model.xfer(1'b1, 8'ha2, 8'h02, 8'h8c, 8'h11, ack, d);
    check(16'(ack), 16'h0001);
    u_host_model.xfer(1'b1, 8'ha2, 8'h02, 8'h8c, 8'h22, ack, d);
    check(16'(ack), 16'h0000);
    idle();
    // Accesses outside this block are not answered
    u_host_model.xfer(1'b0, 8'ha0, 8'h02, 8'h8c, 8'h00, ack, d);
    check(16'(ack), 16'h0000);
    check(16'(mem_hit), 16'h0000);
    u_host_model.xfer(1'b0, 8'ha2, 8'h01, 8'h8c, 8'h00, ack, d);
    check(16'(ack), 16'h0000);
    check(16'(mem_hit), 16'h0000);
    u_host_model.xfer(1'b1, 8'hb2, 8'h02, 8'h8b, 8'h33, ack, d);
    check(16'(ack), 16'h0000);
    check(16'(mem_hit), 16'h0000);
    // values survive a reset and are restored
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rd(8'hb2, 8'h8c, 8'h11);
    rd(8'hb2, 8'h8d, 8'h07);
    scl(tx2_bias, 3'h1, 1'b0);
    scl(tx1_bias, 3'h0, 1'b0);
    scl(tx1_power, 3'h7, 1'b1);
    summarize();
  end
endmodule : testbench
